// File: psr_host_model.sv
// host model: reset pin wiring and watchdog strobe source
`timescale 1ns/1ns
module psr_host_model #(
  parameter int unsigned STROBE_GAP = 50
) (
  input wire logic clk,
  input wire logic oe_n,
  input wire logic button_n,
  input wire logic strobe_en,
  output logic pin_level,
  output logic strobe_n
);
  int unsigned gap_q = 0;
  // pull-up wins unless device or button pulls low
  assign pin_level = oe_n & button_n;
  initial strobe_n = 1'b1;
  // two-cycle low strobe, well inside the timeout
  always @(posedge clk) begin
    gap_q <= (gap_q + 1) % STROBE_GAP;
    strobe_n <= !(strobe_en && gap_q < 2);
  end
endmodule

// File: psr_pkg.sv
// package: constants and carrier types for the processor supervisor reset block
package psr_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned RESET_HOLD_MS = 250;
  localparam int unsigned RESET_HOLD_CYC = (CLK_HZ / 1000) * RESET_HOLD_MS;
  localparam int unsigned DEBOUNCE_US = 20000;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int unsigned WDOG_MS = 1600;
  localparam int unsigned WDOG_CYC = (CLK_HZ / 1000) * WDOG_MS;
  localparam int unsigned CNT_W = 32;
  localparam logic [1:0] CAUSE_NONE = 2'h0;

  typedef enum logic [3:0] {
    PSR_ST_POWERUP = 4'h1,
    PSR_ST_RUN = 4'h2,
    PSR_ST_FAIL = 4'h4,
    PSR_ST_HOLD = 4'h8
  } psr_state_t;

  typedef struct packed {
    logic power_fail;
    logic button;
    logic wdog_expired;
  } psr_cause_t;
endpackage

// File: psr_sync_deb.sv
// module: two-flop synchroniser with stable-level debounce filter
`timescale 1ns/1ns
module psr_sync_deb #(
  parameter int unsigned STABLE_CYC = 16,
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic sync_q;
  logic [31:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  // output follows only after the level stays put for the whole window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
      dout <= RESET_VAL;
    end else if (sync_q == dout) begin
      cnt_q <= 32'h0;
    end else if (cnt_q >= STABLE_CYC - 1) begin
      cnt_q <= 32'h0;
      dout <= sync_q;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule

// File: psr_top.sv
// module: supervisor driving the open-drain processor reset pin
`timescale 1ns/1ns
module psr_top #(
  parameter int unsigned HOLD_CYC = psr_pkg::RESET_HOLD_CYC,
  parameter int unsigned DEB_CYC = psr_pkg::DEBOUNCE_CYC,
  parameter int unsigned WDOG_CYC = psr_pkg::WDOG_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic VCC_FAIL,
  input wire logic WDOG_STROBE_N,
  input wire logic RESET_PIN_IN,
  output logic RESET_PIN_OUT,
  output logic RESET_PIN_OE_N,
  output logic POWER_FAIL,
  output logic RESET_ACTIVE
);
  psr_pkg::psr_state_t state_q;
  psr_pkg::psr_state_t state_d;
  psr_pkg::psr_cause_t cause;
  logic fail_m_q;
  logic fail_s_q;
  logic strobe_m_q;
  logic strobe_s_q;
  logic strobe_prev_q;
  logic pin_deb;
  logic pin_prev_q;
  logic button_hit;
  logic [psr_pkg::CNT_W-1:0] hold_cnt_q;
  logic [psr_pkg::CNT_W-1:0] wdog_cnt_q;
  logic hold_done;
  logic strobe_fall;

  // pin is let go only in the run state
  function automatic logic releases(input psr_pkg::psr_state_t st);
    return st == psr_pkg::PSR_ST_RUN;
  endfunction

  // level synchronisers for the VCC_FAIL and WDOG_STROBE_N pins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fail_m_q <= 1'b1;
      fail_s_q <= 1'b1;
      strobe_m_q <= 1'b1;
      strobe_s_q <= 1'b1;
    end else begin
      fail_m_q <= VCC_FAIL;
      fail_s_q <= fail_m_q;
      strobe_m_q <= WDOG_STROBE_N;
      strobe_s_q <= strobe_m_q;
    end
  end

  // reset pin is sensed back as the button input
  psr_sync_deb #(
    .STABLE_CYC(DEB_CYC),
    .RESET_VAL(1'b0)
  ) u_button (
    .clk(CLK),
    .rst(RST),
    .din(RESET_PIN_IN),
    .dout(pin_deb)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_prev_q <= 1'b0;
      strobe_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= pin_deb;
      strobe_prev_q <= strobe_s_q;
    end
  end

  // an external low only counts while this side is not pulling the pin
  assign button_hit = pin_prev_q && !pin_deb && (state_q == psr_pkg::PSR_ST_RUN);
  assign strobe_fall = strobe_prev_q && !strobe_s_q;
  assign hold_done = (hold_cnt_q >= HOLD_CYC - 1);

  always_comb begin
    cause.power_fail = fail_s_q;
    cause.button = button_hit;
    cause.wdog_expired = (wdog_cnt_q >= WDOG_CYC - 1);
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      psr_pkg::PSR_ST_POWERUP: begin
        if (cause.power_fail) begin
          state_d = psr_pkg::PSR_ST_FAIL;
        end else if (hold_done) begin
          state_d = psr_pkg::PSR_ST_RUN;
        end
      end
      psr_pkg::PSR_ST_RUN: begin
        if (cause.power_fail) begin
          state_d = psr_pkg::PSR_ST_FAIL;
        end else if (cause.button || cause.wdog_expired) begin
          state_d = psr_pkg::PSR_ST_HOLD;
        end
      end
      psr_pkg::PSR_ST_FAIL: begin
        if (!cause.power_fail) begin
          state_d = psr_pkg::PSR_ST_HOLD;
        end
      end
      psr_pkg::PSR_ST_HOLD: begin
        if (cause.power_fail) begin
          state_d = psr_pkg::PSR_ST_FAIL;
        end else if (hold_done) begin
          state_d = psr_pkg::PSR_ST_RUN;
        end
      end
      default: begin
        state_d = psr_pkg::PSR_ST_POWERUP;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= psr_pkg::PSR_ST_POWERUP;
    end else begin
      state_q <= state_d;
    end
  end

  // hold counter restarts on entry to each timed state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hold_cnt_q <= '0;
    end else if (state_d != state_q) begin
      hold_cnt_q <= '0;
    end else if ((state_q == psr_pkg::PSR_ST_POWERUP || state_q == psr_pkg::PSR_ST_HOLD)
                 && !hold_done) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  // watchdog runs only while the processor is out of reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wdog_cnt_q <= '0;
    end else if (state_q != psr_pkg::PSR_ST_RUN || strobe_fall) begin
      wdog_cnt_q <= '0;
    end else if (!cause.wdog_expired) begin
      wdog_cnt_q <= wdog_cnt_q + 1'b1;
    end
  end

  // open drain: data held low, enable low pulls the pin
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RESET_PIN_OUT <= 1'b0;
      RESET_PIN_OE_N <= 1'b0;
      RESET_ACTIVE <= 1'b1;
      POWER_FAIL <= 1'b1;
    end else begin
      RESET_PIN_OUT <= 1'b0;
      RESET_PIN_OE_N <= releases(state_d);
      RESET_ACTIVE <= !releases(state_d);
      POWER_FAIL <= fail_s_q;
    end
  end

  property p_fail_resets;
    @(posedge CLK) disable iff (RST)
      fail_s_q |=> !RESET_PIN_OE_N;
  endproperty
  a_fail_resets: assert property (p_fail_resets) else $error("power fail without reset");

  property p_fail_flag;
    @(posedge CLK) disable iff (RST)
      fail_s_q |=> POWER_FAIL;
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("power-fail flag missing");

  property p_hold_after_fail;
    @(posedge CLK) disable iff (RST)
      (state_q == psr_pkg::PSR_ST_FAIL && !fail_s_q) |=> state_q == psr_pkg::PSR_ST_HOLD
        && hold_cnt_q == '0;
  endproperty
  a_hold_after_fail: assert property (p_hold_after_fail) else $error("no hold after recovery");

  property p_hold_length;
    @(posedge CLK) disable iff (RST)
      (state_q == psr_pkg::PSR_ST_RUN && $past(state_q) == psr_pkg::PSR_ST_HOLD)
        |-> $past(hold_cnt_q) >= HOLD_CYC - 1;
  endproperty
  a_hold_length: assert property (p_hold_length) else $error("reset released early");

  property p_wdog_fire;
    @(posedge CLK) disable iff (RST)
      (state_q == psr_pkg::PSR_ST_RUN && cause.wdog_expired && !fail_s_q)
        |=> state_q == psr_pkg::PSR_ST_HOLD ##1 !RESET_PIN_OE_N;
  endproperty
  a_wdog_fire: assert property (p_wdog_fire) else $error("watchdog expiry ignored");

  property p_button;
    @(posedge CLK) disable iff (RST)
      (button_hit && !fail_s_q) |=> state_q == psr_pkg::PSR_ST_HOLD;
  endproperty
  a_button: assert property (p_button) else $error("button press ignored");

  property p_powerup;
    @(posedge CLK) disable iff (RST)
      state_q == psr_pkg::PSR_ST_POWERUP |-> !RESET_PIN_OE_N;
  endproperty
  a_powerup: assert property (p_powerup) else $error("reset released in power-up");

  property p_wdog_restart;
    @(posedge CLK) disable iff (RST)
      (strobe_fall || state_q != psr_pkg::PSR_ST_RUN) |=> wdog_cnt_q == '0;
  endproperty
  a_wdog_restart: assert property (p_wdog_restart) else $error("watchdog not restarted");
endmodule

// File: tb.sv
// testbench: supervisor reset timing, watchdog and button checks
`timescale 1ns/1ns
module tb;
  localparam int unsigned HOLD = 50;
  localparam int unsigned DEB = 4;
  localparam int unsigned WDOG = 200;
  typedef struct {logic vf; logic ra; int lo; int hi; logic pf;} psr_row_t;
  psr_row_t rows [2];
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vcc_fail = 1'b1;
  logic button_n = 1'b1;
  logic strobe_en = 1'b0;
  logic pin, strobe_n, out, oe_n, pf, ra;
  int bad_count = 0;
  int samples_checked = 0;
  int glitches;
  psr_top #(.HOLD_CYC(HOLD), .DEB_CYC(DEB), .WDOG_CYC(WDOG)) u_dut (
    .CLK(clk), .RST(rst), .VCC_FAIL(vcc_fail), .WDOG_STROBE_N(strobe_n),
    .RESET_PIN_IN(pin), .RESET_PIN_OUT(out), .RESET_PIN_OE_N(oe_n),
    .POWER_FAIL(pf), .RESET_ACTIVE(ra));
  psr_host_model u_host (.clk(clk), .oe_n(oe_n), .button_n(button_n),
    .strobe_en(strobe_en), .pin_level(pin), .strobe_n(strobe_n));
  initial begin
    forever #10 clk = !clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // cycles until reset output reaches v, must land in lo..hi
  task automatic wait_for(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (ra !== v && n <= hi) begin
      @(posedge clk);
      #2;
      n++;
    end
    check(n >= lo && n <= hi, 1'b1);
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (!rst) begin
      check(out, 1'b0);
      check(oe_n, !ra);
    end
  end
  initial begin
    #80000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    rows[0] = '{1'b1, 1'b1, 0, 8, 1'b1};
    rows[1] = '{1'b0, 1'b0, HOLD - 2, HOLD + 10, 1'b0};
    repeat (2) @(posedge clk);
    #2;
    check(ra, 1'b1);
    check(pf, 1'b1);
    check(pin, 1'b0);
    rst = 1'b0;
    vcc_fail = 1'b0;
    wait_for(1'b0, HOLD - 2, HOLD + 12);
    end_test("power_up");
    strobe_en = 1'b1;
    foreach (rows[i]) begin
      vcc_fail = rows[i].vf;
      wait_for(rows[i].ra, rows[i].lo, rows[i].hi);
      check(pf, rows[i].pf);
    end
    end_test("power_fail");
    glitches = 0;
    repeat (3 * WDOG) begin
      @(posedge clk);
      #2;
      if (ra !== 1'b0) glitches++;
    end
    check(glitches, 0);
    strobe_en = 1'b0;
    wait_for(1'b1, WDOG - 55, WDOG + 10);
    strobe_en = 1'b1;
    wait_for(1'b0, HOLD - 2, HOLD + 10);
    end_test("watchdog");
    repeat (5) @(posedge clk);
    #2;
    button_n = 1'b0;
    wait_for(1'b1, DEB, DEB + 10);
    repeat (3) @(posedge clk);
    #2;
    button_n = 1'b1;
    wait_for(1'b0, HOLD - 6, HOLD + 10);
    end_test("button");
    // second reset in mid-run restarts the power-up hold
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    check(ra, 1'b1);
    check(pf, 1'b1);
    check(pin, 1'b0);
    rst = 1'b0;
    wait_for(1'b0, HOLD - 2, HOLD + 12);
    end_test("mid_run_reset");
    tally_and_finish();
  end
endmodule
